// *** include/pwm_pkg.sv ***
package pwm_pkg;
    localparam int unsigned CLK_HZ        = 125_000_000;
    // one unit is 40 oscillator periods (10 us at 4 MHz)
    localparam int unsigned OSC_PER_UNIT  = 40;
    localparam int unsigned REF_OSC_HZ    = 4_000_000;
    localparam int unsigned UNIT_NS       = 10_000;
    localparam int unsigned UNIT_CYCLES   = UNIT_NS / (1_000_000_000 / CLK_HZ);
    localparam int unsigned TIMEOUT_US    = 655_350;
    localparam int unsigned TIMEOUT_UNITS = (TIMEOUT_US * 1000) / UNIT_NS;
    localparam int unsigned CNT_W         = 16;
    localparam int unsigned BYTE_W        = 8;
    localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
    localparam logic [CNT_W-1:0] CNT_ONE  = 16'h0001;
    localparam logic [CNT_W-1:0] CNT_MAX  = 16'hffff;
    localparam logic [CNT_W-1:0] BYTE_MASK = 16'h00ff;

    typedef struct packed {
        logic polarity;
        logic byte_wide;
    } pwm_req_t;

    typedef enum logic [1:0] {
        PWM_IDLE,
        PWM_ARM,
        PWM_WAIT,
        PWM_COUNT
    } pwm_state_t;
endpackage : pwm_pkg

// *** logic/pwm_unit_tick.sv ***
`timescale 1ns/10ps
`default_nettype none
// divider giving one pulse per count unit
module pwm_unit_tick #(
    parameter int unsigned DIV = pwm_pkg::UNIT_CYCLES
) (
    input  wire logic clk_in,
    input  wire logic rst_in,
    input  wire logic clear_in,
    output logic      tick_out
);
    localparam int unsigned W = $clog2(DIV + 1);
    localparam logic [W-1:0] LAST = W'(DIV - 1);
    localparam logic [W-1:0] ZERO = W'(0);
    localparam logic [W-1:0] ONE  = W'(1);

    logic [W-1:0] cnt_q;
    wire          at_last = (cnt_q == LAST);
    wire  [W-1:0] cnt_d   = (clear_in || at_last) ? ZERO : cnt_q + ONE;

    always_ff @(posedge clk_in)
    begin
        if (rst_in)
            cnt_q <= ZERO;
        else
            cnt_q <= cnt_d;
    end

    assign tick_out = at_last && !clear_in;
endmodule : pwm_unit_tick
`default_nettype wire

// *** logic/pwm_meter.sv ***
// How it works
// [RULE1] on a request the pin is switched to input before its transitions are watched.
// [RULE2] a one-bit polarity, 0 low and 1 high, picks the level the pin must enter to start.
// [RULE3] counting starts when the pin enters the chosen level and stops when it leaves it.
// [RULE4] a pin already at the chosen level on request does not start counting until a real entry.
// [RULE5] with no start edge within 0.65535 s the wait is abandoned and zero is returned.
// [RULE6] a word-wide result reports a valid count between 1 and 65535 units.
// [RULE7] one unit is 40 oscillator periods, 10 us at 4 MHz and 2 us at 20 MHz.
// [RULE8] the internal width counter is always 16 bits wide.
// [RULE9] a byte-wide result keeps only the low 8 bits, so 256 reads as zero.
// [RULE10] the counter clears on each request and done pulses one cycle when the result loads.
`timescale 1ns/10ps
`default_nettype none
module pwm_meter #(
    parameter int unsigned TIMEOUT_UNITS = pwm_pkg::TIMEOUT_UNITS,
    parameter int unsigned UNIT_CYCLES   = pwm_pkg::UNIT_CYCLES
) (
    input  wire logic                          clk_in,
    input  wire logic                          rst_in,
    input  wire logic                          start_in,
    input  wire pwm_pkg::pwm_req_t             req_in,
    input  wire logic                          pin_in,
    output logic                               pin_oe_n_out,
    output logic                               pin_drv_out,
    output logic                               busy_out,
    output logic                               done_out,
    output logic                               timeout_out,
    output logic [pwm_pkg::CNT_W-1:0]          result_out
);
    localparam logic [pwm_pkg::CNT_W-1:0] TMO = pwm_pkg::CNT_W'(TIMEOUT_UNITS);

    pwm_pkg::pwm_state_t state_q, state_d;
    pwm_pkg::pwm_req_t   req_q;
    logic                pin_meta_q, pin_sync_q, pin_prev_q;
    logic [pwm_pkg::CNT_W-1:0] cnt_q, wait_q, result_q; // [RULE8]
    logic                done_q, tmo_q, drive_q;
    logic                tick;

    function automatic logic [pwm_pkg::CNT_W-1:0] fit(
        input logic [pwm_pkg::CNT_W-1:0] v,
        input logic                      byte_wide
    );
        fit = byte_wide ? (v & pwm_pkg::BYTE_MASK) : v; // [RULE9]
    endfunction : fit

    wire idle      = (state_q == pwm_pkg::PWM_IDLE);
    wire take      = idle && start_in;
    wire at_level  = (pin_sync_q == req_q.polarity); // [RULE2]
    wire entered   = at_level && (pin_prev_q != req_q.polarity); // [RULE3] [RULE4]
    wire left      = !at_level;
    wire wait_over = tick && (wait_q == TMO - pwm_pkg::CNT_ONE);
    wire cnt_full  = tick && (cnt_q == pwm_pkg::CNT_MAX);
    wire finish_ok = (state_q == pwm_pkg::PWM_COUNT) && (left || cnt_full);
    wire finish_to = (state_q == pwm_pkg::PWM_WAIT) && !entered && wait_over;
    // a pulse ended before any whole unit still reports one unit
    wire [pwm_pkg::CNT_W-1:0] cnt_floor = (cnt_q == pwm_pkg::CNT_ZERO) ? pwm_pkg::CNT_ONE : cnt_q;
    wire [pwm_pkg::CNT_W-1:0] cnt_plus  = cnt_q + pwm_pkg::CNT_ONE;

    pwm_unit_tick #(
        .DIV (UNIT_CYCLES)
    ) u_tick (
        .clk_in   (clk_in),
        .rst_in   (rst_in),
        .clear_in (take || entered),
        .tick_out (tick)
    ); // [RULE7]

    always_comb
    begin
        state_d = state_q;
        unique case (state_q)
            pwm_pkg::PWM_IDLE:  if (start_in) state_d = pwm_pkg::PWM_ARM;
            // one cycle lets the prior level settle into the sampler
            pwm_pkg::PWM_ARM:   state_d = pwm_pkg::PWM_WAIT; // [RULE1]
            pwm_pkg::PWM_WAIT:
            begin
                if (entered)
                    state_d = pwm_pkg::PWM_COUNT;
                else if (wait_over)
                    state_d = pwm_pkg::PWM_IDLE; // [RULE5]
            end
            pwm_pkg::PWM_COUNT: if (finish_ok) state_d = pwm_pkg::PWM_IDLE;
        endcase
    end

    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            pin_meta_q <= 1'b0;
            pin_sync_q <= 1'b0;
        end
        else
        begin
            pin_meta_q <= pin_in;
            pin_sync_q <= pin_meta_q;
        end
    end

    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            state_q    <= pwm_pkg::PWM_IDLE;
            req_q      <= '0;
            pin_prev_q <= 1'b0;
            drive_q    <= 1'b1;
        end
        else
        begin
            state_q    <= state_d;
            pin_prev_q <= pin_sync_q;
            if (take)
            begin
                req_q   <= req_in;
                drive_q <= 1'b0; // [RULE1]
            end
        end
    end

    always_ff @(posedge clk_in)
    begin
        if (rst_in || take)
        begin
            cnt_q  <= pwm_pkg::CNT_ZERO; // [RULE10]
            wait_q <= pwm_pkg::CNT_ZERO;
        end
        else
        begin
            if (state_q == pwm_pkg::PWM_WAIT && tick)
                wait_q <= wait_q + pwm_pkg::CNT_ONE;
            if (state_q == pwm_pkg::PWM_COUNT && tick && !cnt_full)
                cnt_q <= cnt_plus; // [RULE3]
        end
    end

    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            result_q <= pwm_pkg::CNT_ZERO;
            done_q   <= 1'b0;
            tmo_q    <= 1'b0;
        end
        else
        begin
            done_q <= finish_ok || finish_to; // [RULE10]
            if (finish_to)
            begin
                result_q <= pwm_pkg::CNT_ZERO; // [RULE5]
                tmo_q    <= 1'b1;
            end
            else if (finish_ok)
            begin
                result_q <= fit(cnt_floor, req_q.byte_wide); // [RULE6] [RULE9]
                tmo_q    <= 1'b0;
            end
        end
    end

    assign pin_oe_n_out = ~drive_q;
    assign pin_drv_out  = 1'b0;
    assign busy_out     = !idle;
    assign done_out     = done_q;
    assign timeout_out  = tmo_q;
    assign result_out   = result_q;

    sequence s_take;
        take;
    endsequence

    AST_INPUT_ON_REQ: assert property (@(posedge clk_in) disable iff (rst_in) // RULE1
        s_take |=> pin_oe_n_out) else $error("pin not released on request");
    AST_NO_START_AT_LEVEL: assert property (@(posedge clk_in) disable iff (rst_in) // RULE4
        (state_q == pwm_pkg::PWM_WAIT && pin_prev_q == req_q.polarity)
        |=> state_q != pwm_pkg::PWM_COUNT) else $error("count began without edge");
    AST_START_ON_EDGE: assert property (@(posedge clk_in) disable iff (rst_in) // RULE3
        (state_q == pwm_pkg::PWM_WAIT && entered) |=> state_q == pwm_pkg::PWM_COUNT)
        else $error("edge did not start count");
    AST_STOP_ON_LEAVE: assert property (@(posedge clk_in) disable iff (rst_in) // RULE3
        (state_q == pwm_pkg::PWM_COUNT && left) |=> done_out && idle)
        else $error("count did not stop");
    AST_TIMEOUT_ZERO: assert property (@(posedge clk_in) disable iff (rst_in) // RULE5
        finish_to |=> done_out && timeout_out && result_out == pwm_pkg::CNT_ZERO)
        else $error("timeout result not zero");
    AST_WORD_RANGE: assert property (@(posedge clk_in) disable iff (rst_in) // RULE6
        (finish_ok && !req_q.byte_wide) |=> result_out != pwm_pkg::CNT_ZERO)
        else $error("word result zero");
    AST_BYTE_LOW: assert property (@(posedge clk_in) disable iff (rst_in) // RULE9
        (finish_ok && req_q.byte_wide) |=> result_out == (($past(cnt_floor)) & pwm_pkg::BYTE_MASK))
        else $error("byte result wrong");
    AST_CLEAR_ON_REQ: assert property (@(posedge clk_in) disable iff (rst_in) // RULE10
        s_take |=> cnt_q == pwm_pkg::CNT_ZERO && wait_q == pwm_pkg::CNT_ZERO)
        else $error("counter not cleared");
    AST_DONE_ONE: assert property (@(posedge clk_in) disable iff (rst_in) // RULE10
        done_out |=> !done_out) else $error("done longer than one cycle");
    AST_POLARITY: assert property (@(posedge clk_in) disable iff (rst_in) // RULE2
        (state_q == pwm_pkg::PWM_COUNT) |-> $past(pin_sync_q) == req_q.polarity)
        else $error("counting at wrong level");
endmodule : pwm_meter
`default_nettype wire

// *** bench/pwm_pulse_src.sv ***
`timescale 1ns/10ps
`default_nettype none
// far-side source: idles at idle_in, one opposite pulse per fire
module pwm_pulse_src (
    input  wire logic        clk_in,
    input  wire logic        idle_in,
    input  wire logic        fire_in,
    input  wire logic [31:0] width_in,
    output logic             pin_out
);
    logic [31:0] dly_q = 32'h0000_0000;
    logic [31:0] wid_q = 32'h0000_0000;
    always_ff @(posedge clk_in)
    begin
        if (fire_in)
        begin
            dly_q <= 32'h0000_0028;
            wid_q <= width_in;
        end
        else if (dly_q != 32'h0000_0000)
            dly_q <= dly_q - 32'h0000_0001;
        else if (wid_q != 32'h0000_0000)
            wid_q <= wid_q - 32'h0000_0001;
    end
    assign pin_out = (dly_q == 32'h0000_0000 && wid_q != 32'h0000_0000) ? ~idle_in : idle_in;
endmodule : pwm_pulse_src
`default_nettype wire

// *** bench/pulse_width_meter_tb.sv ***
`timescale 1ns/10ps
`default_nettype none
module pulse_width_meter_tb;
    localparam int TO_UNITS = 4;
    localparam int UNIT     = 20;
    logic              clk;
    logic              rst;
    logic              start;
    pwm_pkg::pwm_req_t req;
    logic              idle;
    logic              fire;
    logic [31:0]       width;
    logic              src_pin;
    wire               pin_w;
    logic              oe_n;
    logic              drv;
    logic              busy;
    logic              done;
    logic              tmo;
    logic [15:0]       result;
    int                mismatches;
    int                samples_checked;
    int                cyc;

    // device drives 0 until the pin is turned to input
    assign pin_w = oe_n ? src_pin : drv;

    pwm_meter #(.TIMEOUT_UNITS(TO_UNITS), .UNIT_CYCLES(UNIT)) u_pwm_meter (
        .clk_in(clk), .rst_in(rst), .start_in(start), .req_in(req), .pin_in(pin_w),
        .pin_oe_n_out(oe_n), .pin_drv_out(drv), .busy_out(busy), .done_out(done),
        .timeout_out(tmo), .result_out(result));

    pwm_pulse_src u_pwm_pulse_src (.clk_in(clk), .idle_in(idle), .fire_in(fire),
        .width_in(width), .pin_out(src_pin));

    task automatic chk(input logic [15:0] got, input logic [15:0] lo, input logic [15:0] hi,
                       input string msg);
        samples_checked++;
        if ((got >= lo && got <= hi) !== 1'b1)
        begin
            mismatches++;
            $display("CHECK FAILED %0t %s got %0h", $time, msg, got);
        end
    endtask : chk

    task automatic measure(input logic pol, input logic bw, input logic idl, input int w,
                           input logic [15:0] lo, input logic [15:0] hi, input logic tx);
        @(posedge clk);
        idle <= idl;
        repeat (6) @(posedge clk);
        req   <= '{polarity: pol, byte_wide: bw};
        start <= 1'b1;
        fire  <= 1'b1;
        width <= 32'(w);
        @(posedge clk);
        start <= 1'b0;
        fire  <= 1'b0;
        @(posedge clk);
        #1;
        chk(16'(oe_n), 16'h0001, 16'h0001, "pin not input");
        chk(16'(busy), 16'h0001, 16'h0001, "not busy");
        cyc = 0;
        while (done !== 1'b1 && cyc < 8000)
        begin
            @(posedge clk);
            #1;
            cyc++;
        end
        chk(16'(cyc), 16'h0000, 16'h1f3f, "no done");
        chk(result, lo, hi, "width count");
        chk(16'(tmo), 16'(tx), 16'(tx), "timeout flag");
        @(posedge clk);
        #1;
        chk(16'(done), 16'h0000, 16'h0000, "done too long");
    endtask : measure

    task automatic t_reset;
        @(posedge clk);
        #1;
        chk(16'(oe_n), 16'h0000, 16'h0000, "pin not driven");
        chk(16'(drv), 16'h0000, 16'h0000, "drive level");
        chk(16'(pwm_pkg::UNIT_CYCLES), 16'h04e2, 16'h04e2, "unit length");
        chk(result, 16'h0000, 16'h0000, "result not clear");
    endtask : t_reset

    task automatic t_high;
        measure(1'b1, 1'b0, 1'b0, 5 * UNIT / 2, 16'h0002, 16'h0003, 1'b0);
    endtask : t_high

    task automatic t_low;
        measure(1'b0, 1'b0, 1'b1, 3 * UNIT / 2, 16'h0001, 16'h0002, 1'b0);
    endtask : t_low

    task automatic t_short;
        measure(1'b1, 1'b0, 1'b0, UNIT / 2, 16'h0001, 16'h0001, 1'b0);
    endtask : t_short

    task automatic t_armed;
        measure(1'b1, 1'b0, 1'b1, 0, 16'h0000, 16'h0000, 1'b1);
        chk(16'(cyc), 16'((TO_UNITS - 1) * UNIT), 16'((TO_UNITS + 1) * UNIT), "span");
    endtask : t_armed

    task automatic t_byte;
        measure(1'b1, 1'b1, 1'b0, 5 * UNIT / 2, 16'h0002, 16'h0003, 1'b0);
    endtask : t_byte

    task automatic t_wrap;
        measure(1'b1, 1'b1, 1'b0, 256 * UNIT + UNIT / 2, 16'h0000, 16'h0000, 1'b0);
        measure(1'b1, 1'b0, 1'b0, 256 * UNIT + UNIT / 2, 16'h0100, 16'h0100, 1'b0);
    endtask : t_wrap

    task automatic close_out;
        if (mismatches == 0 && samples_checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : close_out

    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    initial
    begin
        repeat (60000) @(posedge clk);
        mismatches++;
        close_out();
    end

    initial
    begin
        mismatches = 0;
        samples_checked = 0;
        rst = 1'b1;
        start = 1'b0;
        req = '0;
        idle = 1'b0;
        fire = 1'b0;
        width = 32'h0000_0000;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_high();
        t_low();
        t_short();
        t_armed();
        t_byte();
        t_wrap();
        close_out();
    end
endmodule : pulse_width_meter_tb
`default_nettype wire
